// [rtl/hall_sample_sequencer.sv]
// sampling sequencer: mode pin decode, conversion timing, output code
//
// Operation
// - pin held low runs self-timed sampling at about 24 Hz.
// - mode pin has internal pull-down, floating pin selects low-rate mode.
// - pin held high samples back to back, 16 ticks (160 us) each.
// - pulsed conversion takes 14 ticks of 10 us, 140 us total.
// - after a rising edge, wait one 10 us tick in low power.
// - then stay awake acquiring for 12 ticks, 120 us.
// - then one 10 us tick updating the output, then low power.
// - each sample quantized to 8 bits and that code drives the output.
// - output codes span zero up to 255, the full-scale code.
// - zero field is the 127/128 boundary; slightly positive gives mid-scale.
// - south raises code, north lowers it, symmetric and proportional.
// - output valid only after power-on settling time has elapsed.
// - power-on settling time is typically 1 ms.
`timescale 1ns/1ps
`default_nettype none
`include "hall_sample_map.svh"
module hall_sample_sequencer
   import hall_sample_pkg::*;
#(
   parameter int FIELD_W = 12,
   parameter int FRAC_W = 4,
   parameter int PRESC_W = 9,
   parameter int unsigned LOW_RATE_CYCLES = `NS_PER_S / (`LOW_RATE_HZ * `CLK_PERIOD_NS),
   parameter int unsigned POWERON_CYCLES = `POWERON_TIME_US * `NS_PER_US / `CLK_PERIOD_NS
) (
   // clock and reset
   input wire logic clock,
   input wire logic rst,
   // mode pin
   input wire logic mode_control_input,
   output logic pulldown_enable,
   // analog front end
   input wire logic signed [FIELD_W-1:0] field_sample,
   // output stage
   output code_t dac_code,
   output logic output_valid,
   // status
   output logic awake,
   output logic conv_done
);

   localparam logic [PRESC_W-1:0] TICK_LAST = PRESC_W'(`TICK_CYCLES - 1);
   localparam logic [3:0] DELAY_LAST = 4'(`TRIG_DELAY_TICKS - 1);
   localparam logic [3:0] AWAKE_LAST = 4'(`AWAKE_TICKS - 1);
   localparam logic [3:0] UPDATE_LAST = 4'(`UPDATE_TICKS - 1);
   localparam logic [3:0] REST_LAST = 4'(`TURBO_CONV_TICKS - `CONV_TICKS - 1);
   localparam logic [31:0] LOW_DUE = 32'(LOW_RATE_CYCLES - 1);
   localparam logic [31:0] POR_DONE = 32'(POWERON_CYCLES);

   // ***********************************
   // pin synchronizer
   // ***********************************
   logic pin_meta;
   logic pin_sync;
   logic pin_prev;

   always_ff @(posedge clock) begin
      if (rst) begin
         pin_meta <= 1'b0;
         pin_sync <= 1'b0;
         pin_prev <= 1'b0;
      end else begin
         pin_meta <= mode_control_input;
         pin_sync <= pin_meta;
         pin_prev <= pin_sync;
      end
   end

   // internal pull-down always on
   assign pulldown_enable = 1'b1;

   // ***********************************
   // sequencer
   // ***********************************
   seq_state_t state;
   seq_state_t next_state;
   logic [PRESC_W-1:0] presc;
   logic [PRESC_W-1:0] next_presc;
   logic [3:0] phase;
   logic [3:0] next_phase;
   logic went_low;
   logic next_went_low;
   logic [31:0] age;
   logic [31:0] next_age;
   logic tick;
   logic last;
   logic pin_rise;
   logic low_due;
   logic hold_high;
   logic start;
   logic sample;
   code_t quant_code;

   function automatic logic [3:0] phase_last(input seq_state_t s);
      unique case (s)
         st_idle: phase_last = '0;
         st_trig_delay: phase_last = DELAY_LAST;
         st_awake: phase_last = AWAKE_LAST;
         st_update: phase_last = UPDATE_LAST;
         st_rest: phase_last = REST_LAST;
         default: phase_last = '0;
      endcase
   endfunction

   assign tick = (presc == TICK_LAST);
   assign last = tick && (phase == phase_last(state));
   assign pin_rise = pin_sync && !pin_prev;
   assign low_due = !pin_sync && (age >= LOW_DUE);
   assign hold_high = pin_sync && !went_low;
   // starts only from idle or the turbo rest; edges elsewhere drop
   assign start = ((state == st_idle) && (pin_rise || low_due)) || ((state == st_rest) && last);
   assign sample = (state == st_awake) && last;
   assign conv_done = (state == st_update) && last;
   assign awake = (state == st_awake);

   always_comb begin
      next_state = state;
      next_presc = presc;
      next_phase = phase;
      next_went_low = went_low;
      next_age = (age == '1) ? age : age + 32'h1;
      if (start) begin
         next_state = st_trig_delay;
         next_presc = '0;
         next_phase = '0;
         next_went_low = !pin_sync;
         next_age = '0;
      end else if (state != st_idle) begin
         next_presc = tick ? '0 : presc + PRESC_W'(1);
         if (!pin_sync) begin
            next_went_low = 1'b1;
         end
         if (last) begin
            next_phase = '0;
            unique case (state)
               st_trig_delay: next_state = st_awake;
               st_awake: next_state = st_update;
               st_update: next_state = hold_high ? st_rest : st_idle;
               default: next_state = state;
            endcase
         end else if (tick) begin
            next_phase = phase + 4'h1;
         end
      end
   end

   always_ff @(posedge clock) begin
      if (rst) begin
         state <= st_idle;
         presc <= '0;
         phase <= '0;
         went_low <= 1'b1;
         age <= '0;
      end else begin
         state <= next_state;
         presc <= next_presc;
         phase <= next_phase;
         went_low <= next_went_low;
         age <= next_age;
      end
   end

   hall_code_quantizer #(
      .FIELD_W(FIELD_W),
      .FRAC_W(FRAC_W)
   ) u_quantizer (
      .clock(clock),
      .rst(rst),
      .load(sample),
      .field(field_sample),
      .code(quant_code)
   );

   // ***********************************
   // output stage and power-on settling
   // ***********************************
   code_t next_dac_code;
   logic [31:0] por_cnt;
   logic [31:0] next_por_cnt;
   logic next_output_valid;

   always_comb begin
      next_dac_code = conv_done ? quant_code : dac_code;
      next_por_cnt = (por_cnt == POR_DONE) ? por_cnt : por_cnt + 32'h1;
      next_output_valid = output_valid || (por_cnt == POR_DONE - 32'h1);
   end

   always_ff @(posedge clock) begin
      if (rst) begin
         dac_code <= `CODE_MID;
         por_cnt <= '0;
         output_valid <= 1'b0;
      end else begin
         dac_code <= next_dac_code;
         por_cnt <= next_por_cnt;
         output_valid <= next_output_valid;
      end
   end

   // ***********************************
   // checks
   // ***********************************
   localparam int UPD_WAIT = `TICK_CYCLES - 1;
   localparam logic [31:0] AWAKE_START = 32'(`TICK_CYCLES * `TRIG_DELAY_TICKS);
   localparam logic [31:0] AWAKE_END = 32'(`TICK_CYCLES * (`TRIG_DELAY_TICKS + `AWAKE_TICKS));
   localparam logic [31:0] CONV_END = 32'(`TICK_CYCLES * `CONV_TICKS - 1);
   localparam logic [31:0] TURBO_END = 32'(`TICK_CYCLES * `TURBO_CONV_TICKS - 1);

   sequence s_awake_end;
      $fell(awake);
   endsequence

   sequence s_update_then_sleep;
      ##[UPD_WAIT:UPD_WAIT] conv_done ##1 (state == st_idle || state == st_rest);
   endsequence

   property p_low_rate;
      @(posedge clock) disable iff (rst)
         (state == st_idle && !pin_sync && !pin_rise && age == LOW_DUE) |=> state == st_trig_delay;
   endproperty
   a_low_rate: assert property (p_low_rate) else $error("self-timed sample missed");

   property p_pulldown;
      @(posedge clock) disable iff (rst) pulldown_enable;
   endproperty
   a_pulldown: assert property (p_pulldown) else $error("pull-down released");

   property p_turbo_period;
      @(posedge clock) disable iff (rst) (start && state == st_rest) |-> age == TURBO_END;
   endproperty
   a_turbo_period: assert property (p_turbo_period) else $error("turbo period wrong");

   property p_conv_len;
      @(posedge clock) disable iff (rst) conv_done |-> age == CONV_END;
   endproperty
   a_conv_len: assert property (p_conv_len) else $error("conversion length wrong");

   property p_trig_delay;
      @(posedge clock) disable iff (rst) $rose(awake) |-> age == AWAKE_START;
   endproperty
   a_trig_delay: assert property (p_trig_delay) else $error("trigger delay wrong");

   property p_awake_len;
      @(posedge clock) disable iff (rst) $fell(awake) |-> age == AWAKE_END;
   endproperty
   a_awake_len: assert property (p_awake_len) else $error("awake window wrong");

   property p_update;
      @(posedge clock) disable iff (rst) s_awake_end |-> s_update_then_sleep;
   endproperty
   a_update: assert property (p_update) else $error("update tick wrong");

   property p_code_load;
      @(posedge clock) disable iff (rst) conv_done |=> dac_code == $past(quant_code);
   endproperty
   a_code_load: assert property (p_code_load) else $error("output code not updated");

   property p_valid_time;
      @(posedge clock) disable iff (rst) $rose(output_valid) |-> por_cnt == POR_DONE;
   endproperty
   a_valid_time: assert property (p_valid_time) else $error("valid at wrong time");

   property p_not_early;
      @(posedge clock) disable iff (rst) (por_cnt < POR_DONE) |-> !output_valid;
   endproperty
   a_not_early: assert property (p_not_early) else $error("valid before settling");

   property p_ignore_edge;
      @(posedge clock) disable iff (rst)
         (pin_rise && (state == st_awake || state == st_update)) |=> state != st_trig_delay;
   endproperty
   a_ignore_edge: assert property (p_ignore_edge) else $error("edge restarted conversion");

   property p_mode_select;
      @(posedge clock) disable iff (rst)
         conv_done |=> (state == (($past(pin_sync) && !$past(went_low)) ? st_rest : st_idle));
   endproperty
   a_mode_select: assert property (p_mode_select) else $error("mode decode wrong");

endmodule
`default_nettype wire

// [common/hall_sample_map.svh]
// timing and code constants of the hall sample sequencer
`ifndef HALL_SAMPLE_MAP_SVH
`define HALL_SAMPLE_MAP_SVH

// ***********************************
// clock and internal tick
// ***********************************
`define CLK_PERIOD_NS 25
`define TICK_TIME_NS 10000
`define TICK_CYCLES (`TICK_TIME_NS / `CLK_PERIOD_NS)

// ***********************************
// conversion sequence, in ticks
// ***********************************
`define TRIG_DELAY_TICKS 1
`define AWAKE_TICKS 12
`define UPDATE_TICKS 1
`define CONV_TICKS 14
`define TURBO_CONV_TICKS 16

// ***********************************
// self-timed rate and power-on settling
// ***********************************
`define LOW_RATE_HZ 24
`define NS_PER_S 1000000000
`define POWERON_TIME_US 1000
`define NS_PER_US 1000

// ***********************************
// output codes
// ***********************************
`define CODE_MID 8'h80
`define CODE_MAX 8'hff
`define CODE_MIN 8'h00
`define CODE_BIAS 128

`endif

// [common/hall_sample_pkg.sv]
// types shared by the hall sample sequencer
`default_nettype none
package hall_sample_pkg;
   typedef enum logic [2:0] {st_idle, st_trig_delay, st_awake, st_update, st_rest} seq_state_t;
   typedef logic [7:0] code_t;
endpackage
`default_nettype wire

// [rtl/hall_code_quantizer.sv]
// field sample to 8-bit output code quantizer
`timescale 1ns/1ps
`default_nettype none
`include "hall_sample_map.svh"
module hall_code_quantizer
   import hall_sample_pkg::*;
#(
   parameter int FIELD_W = 12,
   parameter int FRAC_W = 4
) (
   // clock and reset
   input wire logic clock,
   input wire logic rst,
   // sample capture
   input wire logic load,
   input wire logic signed [FIELD_W-1:0] field,
   // quantized code
   output code_t code
);

   code_t next_code;

   // floor to whole steps, bias so zero field sits on the 127/128 boundary
   function automatic code_t to_code(input logic signed [FIELD_W-1:0] f);
      logic signed [FIELD_W+1:0] steps;
      logic signed [FIELD_W+1:0] biased;
      steps = (FIELD_W+2)'(f) >>> FRAC_W;
      biased = steps + (FIELD_W+2)'(`CODE_BIAS);
      // limits compared as signed so a negative sum clamps low
      if (biased > $signed((FIELD_W+2)'(`CODE_MAX))) begin
         to_code = `CODE_MAX;
      end else if (biased < $signed((FIELD_W+2)'(`CODE_MIN))) begin
         to_code = `CODE_MIN;
      end else begin
         to_code = biased[7:0];
      end
   endfunction

   always_comb begin
      next_code = code;
      if (load) begin
         next_code = to_code(field);
      end
   end

   always_ff @(posedge clock) begin
      if (rst) begin
         code <= `CODE_MID;
      end else begin
         code <= next_code;
      end
   end

   // ***********************************
   // checks
   // ***********************************
   property p_above_zero;
      @(posedge clock) disable iff (rst) (load && field > 0) |=> code >= `CODE_MID;
   endproperty
   a_above_zero: assert property (p_above_zero) else $error("positive field below mid-scale");

   property p_north;
      @(posedge clock) disable iff (rst) (load && field < 0) |=> code < `CODE_MID;
   endproperty
   a_north: assert property (p_north) else $error("north field not below mid-scale");

   property p_full_scale;
      @(posedge clock) disable iff (rst)
         (load && (field >>> FRAC_W) >= (`CODE_BIAS - 1)) |=> code == `CODE_MAX;
   endproperty
   a_full_scale: assert property (p_full_scale) else $error("full field not at top code");

endmodule
`default_nettype wire

// [testbench/hall_pin_driver.sv]
// external controller model that drives the mode pin
`timescale 1ns/1ps
`default_nettype none
module hall_pin_driver (
   // clock
   input wire logic clock,
   // command: 0 release, 1 low, 2 high, 3 start pulse
   input wire logic [1:0] cmd,
   input wire logic [11:0] width,
   input wire logic no_gap,
   // pin drive
   output logic pin_level,
   output logic pin_oe
);
   int hi_cnt;
   int gap_cnt;
   initial begin
      pin_level = 1'b0;
      pin_oe = 1'b0;
      hi_cnt = 0;
      gap_cnt = 5600;
   end
   always @(negedge clock) begin
      gap_cnt <= gap_cnt + 1;
      if (hi_cnt > 1) begin
         hi_cnt <= hi_cnt - 1;
      end else if (hi_cnt == 1) begin
         hi_cnt <= 0;
         pin_level <= 1'b0;
      end else if (cmd == 2'h3) begin
         // starts no closer than 140 us unless a scenario asks
         if (gap_cnt >= 5600 || no_gap) begin
            hi_cnt <= (width < 12'h320) ? 800 : int'(width);
            pin_level <= 1'b1;
            pin_oe <= 1'b1;
            gap_cnt <= 0;
         end
      end else begin
         pin_oe <= (cmd != 2'h0);
         pin_level <= (cmd == 2'h2);
      end
   end
endmodule
`default_nettype wire

// [testbench/hall_sample_sequencer_test.sv]
// self-checking bench of the hall sample sequencer
`timescale 1ns/1ps
`default_nettype none
module hall_sample_sequencer_test;
   import hall_sample_pkg::*;
   logic clock, rst, pin, pin_level, pin_oe, pulldown_enable, output_valid;
   logic awake, conv_done, no_gap, awake_d;
   logic [1:0] cmd;
   logic [11:0] width;
   logic signed [11:0] field_sample;
   code_t dac_code;
   int cyc, n_rise, n_done, t_rise, t_prev, t_fall, t_done, t_edge, k, r0, seed;
   int mismatches, n_compared;
   // released pin follows the internal pull
   assign pin = pin_oe ? pin_level : !pulldown_enable;
   hall_pin_driver DRV (.clock(clock), .cmd(cmd), .width(width), .no_gap(no_gap),
      .pin_level(pin_level), .pin_oe(pin_oe));
   hall_sample_sequencer #(.POWERON_CYCLES(50), .LOW_RATE_CYCLES(20000)) DUT (
      .clock(clock), .rst(rst), .mode_control_input(pin),
      .pulldown_enable(pulldown_enable), .field_sample(field_sample),
      .dac_code(dac_code), .output_valid(output_valid), .awake(awake),
      .conv_done(conv_done));
   initial begin
      clock = 1'b0;
      forever #12.5 clock = ~clock;
   end
   // ***********************************
   // event monitor and timeout
   // ***********************************
   always @(posedge clock) begin
      cyc <= cyc + 1;
      awake_d <= awake;
      if (awake === 1'b1 && awake_d === 1'b0) begin
         t_prev <= t_rise;
         t_rise <= cyc;
         n_rise <= n_rise + 1;
      end
      if (awake === 1'b0 && awake_d === 1'b1) t_fall <= cyc;
      if (conv_done === 1'b1) begin
         t_done <= cyc;
         n_done <= n_done + 1;
      end
      if (cyc == 100000) begin
         mismatches = mismatches + 1;
         end_of_test();
      end
   end
   // ***********************************
   // expectations and compares
   // ***********************************
   function automatic code_t exp_code(logic signed [11:0] f);
      int v;
      v = (f >>> 4) + 128;
      if (v > 255) v = 255;
      if (v < 0) v = 0;
      return v[7:0];
   endfunction
   task automatic check_code(code_t got, code_t want);
      n_compared++;
      if (got !== want) begin
         mismatches++;
         $display("ERROR t=%0t got=%h want=%h", $time, got, want);
      end
   endtask
   task automatic check_num(int got, int want);
      n_compared++;
      if (got !== want) begin
         mismatches++;
         $display("ERROR t=%0t got=%h want=%h", $time, got, want);
      end
   endtask
   task automatic check_bit(logic got, logic want);
      n_compared++;
      if (got !== want) begin
         mismatches++;
         $display("ERROR t=%0t got=%h want=%h", $time, got, want);
      end
   endtask
   task automatic wait_evt(ref int cnt, input int lim);
      int c0;
      c0 = cnt;
      for (int i = 0; i < lim && cnt == c0; i++) @(negedge clock);
      check_bit(cnt != c0, 1'b1);
   endtask
   task automatic pulse(logic signed [11:0] f, logic [11:0] w);
      field_sample <= f;
      width <= w;
      cmd <= 2'h3;
      @(negedge clock);
      cmd <= 2'h1;
      t_edge = cyc;
   endtask
   task automatic run_pulse(logic signed [11:0] f, logic [11:0] w);
      pulse(f, w);
      wait_evt(n_done, 6000);
      check_code(dac_code, exp_code(f));
      check_bit((t_rise - t_edge) inside {[400:406]}, 1'b1);
      check_num(t_fall - t_rise, 4800);
      check_num(t_done - t_fall, 399);
   endtask
   task automatic end_of_test();
      $display("compared %0d mismatches %0d", n_compared, mismatches);
      if (mismatches == 0 && n_compared > 0) begin
         $display("STATUS OK");
      end else begin
         $display("STATUS NOT OK");
      end
      $finish;
   endtask
   // ***********************************
   // scenarios
   // ***********************************
   initial begin
      seed = 10739;
      {cyc, n_rise, n_done, t_rise, t_prev, t_fall, t_done, mismatches, n_compared} = '0;
      rst = 1'b1;
      cmd = 2'h0;
      width = 12'h640;
      no_gap = 1'b0;
      awake_d = 1'b0;
      field_sample = -12'sh1;
      repeat (12) @(negedge clock);
      check_code(dac_code, 8'h80);
      check_bit(output_valid, 1'b0);
      check_bit(pulldown_enable, 1'b1);
      rst = 1'b0;
      for (k = 0; k < 60 && output_valid !== 1'b1; k++) @(negedge clock);
      check_bit(k inside {[49:51]}, 1'b1);
      wait_evt(n_rise, 21000);
      wait_evt(n_done, 6000);
      check_code(dac_code, 8'h7f);
      field_sample = 12'sh7f0;
      wait_evt(n_rise, 21000);
      check_num(t_rise - t_prev, 20000);
      wait_evt(n_done, 6000);
      check_code(dac_code, 8'hff);
      run_pulse(12'sh800, 12'h640);
      run_pulse(12'sh0, 12'h320);
      run_pulse(12'($random(seed)), 12'h640 + 12'($random(seed) & 'h1ff));
      r0 = n_done;
      k = n_rise;
      pulse(12'sh064, 12'h320);
      repeat (2000) @(negedge clock);
      no_gap <= 1'b1;
      pulse(12'sh064, 12'h320);
      no_gap <= 1'b0;
      repeat (6000) @(negedge clock);
      check_num(n_done - r0, 1);
      check_num(n_rise - k, 1);
      check_code(dac_code, exp_code(12'sh064));
      cmd <= 2'h2;
      wait_evt(n_rise, 1000);
      wait_evt(n_rise, 7000);
      check_num(t_rise - t_prev, 6400);
      end_of_test();
   end
endmodule
`default_nettype wire
